/* core/rotdp_pkg.sv */
// Purpose: Constants for the rotate instruction datapath
// Assumes: 16-bit program word, 8-bit data, 12-bit data address
// Notes: Opcode patterns compared on the upper six bits of the word
// What this block does
// - Rotate left without carry: bit n goes to n+1, bit 7 to bit 0.
// - Byte file address 0..255; left rotate updates N and Z only.
// - Destination bit 0 writes working register, 1 writes file register.
// - Bank bit 0 picks access bank, 1 uses the bank select register.
// - Bank bit 0, extended set, address up to 95: indexed literal offset.
// - Rotate right through carry: bit 0 to carry, old carry to bit 7.
package rotdp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int WORD_W = 16;
  localparam logic [5:0] OPC_RLNC = 6'h11; // 0100 01
  localparam logic [5:0] OPC_RRC = 6'h0C; // 0011 00
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 10;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam logic [7:0] ILO_LIMIT = 8'h5F; // 95
  localparam logic [7:0] ACC_SPLIT = 8'h60; // Low access half boundary
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [3:0] BSR_RST = 4'h0;
  typedef enum logic [1:0] {
    ROTDP_Q1,
    ROTDP_Q2,
    ROTDP_Q3,
    ROTDP_Q4
  } rotdp_phase_t;
endpackage

/* core/rotdp_alu.sv */
// Purpose: Combinational rotate unit
// Assumes: Opcode already classified by the caller
// Notes: N and Z outputs follow the result, carry does not; the unit has no valid output
`timescale 1ns/1ps
module rotdp_alu (
  input wire logic [7:0] src,
  input wire logic carry_in,
  input wire logic is_right,
  output logic [7:0] result,
  output logic carry_out,
  output logic neg_out,
  output logic zero_out
);
  // Both rotations, chosen by instruction kind
  wire [7:0] left_w = {src[6:0], src[7]};
  wire [7:0] right_w = {carry_in, src[7:1]};
  assign result = is_right ? right_w : left_w;
  assign carry_out = is_right ? src[0] : carry_in;
  assign neg_out = result[7];
  assign zero_out = (result == 8'h00);
endmodule

/* core/rotdp_core.sv */
// Purpose: Rotate instruction datapath on four-phase instruction cycle
// Assumes: File memory read data valid one phase after address issue
// Notes: Other opcodes are ignored; their words take a cycle doing nothing
`timescale 1ns/1ps
module rotdp_core #(
  parameter int PHASES = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [rotdp_pkg::WORD_W-1:0] instr_word,
  input wire logic ext_set_en,
  input wire logic [3:0] bank_select_register,
  input wire logic [rotdp_pkg::ADDR_W-1:0] fsr2_base,
  input wire logic [7:0] mem_rdata,
  output logic [rotdp_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic [7:0] working_register,
  output logic carry_flag,
  output logic neg_flag,
  output logic zero_flag,
  output logic instr_done,
  output logic [1:0] phase
);
  import rotdp_pkg::*;

  // Only the four-phase cycle is built, so refuse others at elaboration
  if (PHASES != 4) begin : g_bad_phases
    $error("rotdp_core supports exactly four phases");
  end

  // Reset release through two flops
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  rotdp_phase_t ph_q, ph_d;
  logic [WORD_W-1:0] ir_q;
  logic active_q;
  logic [7:0] src_q;
  logic [7:0] res_q;
  logic cres_q;
  logic nres_q;
  logic zres_q;

  // Instruction field decode
  wire [5:0] opc_w = instr_word[OPC_MSB:OPC_LSB];
  wire is_rl_w = (opc_w == OPC_RLNC);
  wire is_rr_w = (opc_w == OPC_RRC);
  wire is_rot_w = instr_valid && (is_rl_w || is_rr_w);
  wire [7:0] f_w = instr_word[7:0];
  wire a_w = instr_word[BANK_BIT];
  wire d_q_w = ir_q[DEST_BIT];
  wire rr_q_w = (ir_q[OPC_MSB:OPC_LSB] == OPC_RRC);

  // Effective address forming
  wire ilo_w = !a_w && ext_set_en && (f_w <= ILO_LIMIT);
  wire [ADDR_W-1:0] ilo_addr_w = fsr2_base + {4'h0, f_w};
  wire [3:0] acc_bank_w = (f_w < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK;
  wire [3:0] bank_w = a_w ? bank_select_register : acc_bank_w;
  wire [ADDR_W-1:0] ea_w = ilo_w ? ilo_addr_w : {bank_w, f_w};

  // Rotate unit
  logic [7:0] alu_res;
  logic alu_c, alu_n, alu_z;
  rotdp_alu u_alu (
    .src(src_q),
    .carry_in(carry_flag),
    .is_right(rr_q_w),
    .result(alu_res),
    .carry_out(alu_c),
    .neg_out(alu_n),
    .zero_out(alu_z)
  );

  // Phase sequencer, free running
  always_comb begin
    case (ph_q)
      ROTDP_Q1: ph_d = ROTDP_Q2;
      ROTDP_Q2: ph_d = ROTDP_Q3;
      ROTDP_Q3: ph_d = ROTDP_Q4;
      ROTDP_Q4: ph_d = ROTDP_Q1;
      default: ph_d = ROTDP_Q1;
    endcase
  end

  // Q1 decode, Q2 read, Q3 process, Q4 write
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ph_q <= ROTDP_Q1;
      ir_q <= 16'h0000;
      active_q <= 1'b0;
      src_q <= 8'h00;
      res_q <= 8'h00;
      cres_q <= 1'b0;
      nres_q <= 1'b0;
      zres_q <= 1'b0;
      mem_addr <= 12'h000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
      working_register <= W_RST;
      carry_flag <= 1'b0;
      neg_flag <= 1'b0;
      zero_flag <= 1'b0;
      instr_done <= 1'b0;
    end else begin
      ph_q <= ph_d;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      instr_done <= 1'b0;
      case (ph_q)
        ROTDP_Q1: begin
          active_q <= is_rot_w;
          ir_q <= instr_word;
          mem_addr <= ea_w;
          mem_rd <= is_rot_w;
        end
        ROTDP_Q2: begin
          src_q <= mem_rdata;
        end
        ROTDP_Q3: begin
          res_q <= alu_res;
          cres_q <= alu_c;
          nres_q <= alu_n;
          zres_q <= alu_z;
        end
        ROTDP_Q4: begin
          if (active_q) begin
            instr_done <= 1'b1;
            neg_flag <= nres_q;
            zero_flag <= zres_q;
            carry_flag <= cres_q;
            if (d_q_w) begin
              mem_wr <= 1'b1;
              mem_wdata <= res_q;
            end else begin
              working_register <= res_q;
            end
          end
        end
        default: ;
      endcase
    end
  end
  assign phase = ph_q;

  // Checks
  AST_LEFT_ROT: assert property (
    @(posedge clk_sys) disable iff (!rst_n_q)
    (ph_q == ROTDP_Q4 && active_q && !rr_q_w)
    |-> res_q == {src_q[6:0], src_q[7]})
    else $error("left rotate result wrong");
  AST_LEFT_CARRY: assert property (
    @(posedge clk_sys) disable iff (!rst_n_q)
    (instr_done && !rr_q_w) |-> $stable(carry_flag))
    else $error("left rotate changed carry");
  AST_DEST_W: assert property (
    @(posedge clk_sys) disable iff (!rst_n_q)
    (ph_q == ROTDP_Q4 && active_q && !d_q_w)
    |=> working_register == $past(res_q) && !mem_wr)
    else $error("working register not written");
  AST_DEST_F: assert property (
    @(posedge clk_sys) disable iff (!rst_n_q)
    (ph_q == ROTDP_Q4 && active_q && d_q_w)
    |=> mem_wr && mem_wdata == $past(res_q))
    else $error("file register not written");
  AST_BANK: assert property (
    @(posedge clk_sys) disable iff (!rst_n_q)
    (ph_q == ROTDP_Q1 && is_rot_w && a_w)
    |=> mem_addr == {$past(bank_select_register), $past(f_w)})
    else $error("banked address wrong");
  AST_ILO: assert property (
    @(posedge clk_sys) disable iff (!rst_n_q)
    (ph_q == ROTDP_Q1 && is_rot_w && ilo_w)
    |=> mem_addr == $past(ilo_addr_w))
    else $error("indexed offset address wrong");
  AST_RIGHT_CARRY: assert property (
    @(posedge clk_sys) disable iff (!rst_n_q)
    (ph_q == ROTDP_Q3 && active_q && rr_q_w)
    |=> res_q == {$past(carry_flag), $past(src_q[7:1])}
    ##1 carry_flag == $past(src_q[0], 2))
    else $error("right rotate through carry wrong");
  AST_ONE_CYCLE: assert property (
    @(posedge clk_sys) disable iff (!rst_n_q)
    (ph_q == ROTDP_Q1 && is_rot_w) |-> ##4 instr_done)
    else $error("rotate did not finish in one cycle");
  // Flags checked against the result byte, not the unit's own flag outputs
  AST_FLAGS: assert property (
    @(posedge clk_sys) disable iff (!rst_n_q)
    instr_done |-> zero_flag == (res_q == 8'h00) && neg_flag == res_q[7])
    else $error("N or Z flag wrong");
endmodule

/* dv/rotdp_mem.sv */
// Purpose: Data memory model facing the rotate datapath
// Assumes: Read data is sampled in the cycle of mem_rd or the one after
// Notes: Outside a read the data lines toggle; after a read the stale byte shows every other cycle
`timescale 1ns/1ps
module rotdp_mem (
  input wire logic clk_sys,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:4095];
  logic rd_q = 1'b0;
  logic [7:0] junk_q = 8'hA5;
  // Wide read window, so either sample edge sees the byte
  assign mem_rdata = (mem_rd || rd_q) ? mem[mem_addr] : junk_q;
  // Write-back is taken on the write pulse only
  always @(posedge clk_sys) begin
    rd_q <= mem_rd;
    junk_q <= ~mem_rdata;
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule

/* dv/rotate_instruction_datapath_tb.sv */
// Purpose: Self-checking bench for the rotate datapath
// Assumes: Words are offered only at the Q1 edge
// Notes: Carry is tracked across scenarios, so order matters
`timescale 1ns/1ps
module rotate_instruction_datapath_tb;
  logic clk_sys, instr_valid, mem_rd, mem_wr, instr_done;
  logic resetn, ext_set_en, carry_flag, neg_flag, zero_flag;
  logic [15:0] instr_word;
  logic [3:0] bank_select_register;
  logic [11:0] fsr2_base, mem_addr;
  logic [7:0] mem_rdata, mem_wdata, working_register;
  logic [1:0] phase;
  int bad_count = 0;
  int check_count = 0;
  rotdp_core dut (.clk_sys, .resetn, .instr_valid, .instr_word,
    .ext_set_en, .bank_select_register, .fsr2_base, .mem_rdata,
    .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .working_register,
    .carry_flag, .neg_flag, .zero_flag, .instr_done, .phase);
  rotdp_mem mem_m (.clk_sys, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .mem_rdata);
  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(string s, logic [11:0] e, logic [11:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One instruction: preload, launch in Q1, watch read and write phases
  task automatic run(logic [15:0] w, logic [11:0] ea, logic [7:0] src,
    logic [7:0] res, logic [2:0] cnz, logic ok);
    int n;
    logic rd_seen;
    logic done_seen;
    logic [11:0] rd_n;
    logic [11:0] done_n;
    mem_m.mem[ea] = src;
    rd_seen = 1'b0;
    done_seen = 1'b0;
    rd_n = 12'h7;
    done_n = 12'h7;
    for (n = 0; n < 8 && phase !== 2'h0; n++) @(posedge clk_sys) #1;
    if (phase !== 2'h0) begin
      bad_count++;
      $display("Error phase expected 0 seen %h", phase);
      tally_and_finish();
    end
    instr_word = w;
    instr_valid = 1'b1;
    @(posedge clk_sys) #1 instr_valid = 1'b0;
    for (n = 0; n < 6; n++) begin
      if (mem_rd === 1'b1) begin
        rd_seen = 1'b1;
        rd_n = n[11:0];
        chk("addr", ea, mem_addr);
      end
      if (instr_done === 1'b1) begin
        done_seen = 1'b1;
        done_n = n[11:0];
        chk("result", res, w[9] ? mem_wdata : working_register);
        chk("write", w[9], mem_wr);
        chk("flags", cnz, {carry_flag, neg_flag, zero_flag});
        chk("phase", 12'h0, phase);
      end
      @(posedge clk_sys) #1;
    end
    chk("read", ok, rd_seen);
    chk("done", ok, done_seen);
    chk("read cycle", ok ? 12'h0 : 12'h7, rd_n);
    chk("done cycle", ok ? 12'h3 : 12'h7, done_n);
    chk("stored", (w[9] && ok) ? res : src, mem_m.mem[ea]);
  endtask
  task automatic t_right;
    ext_set_en = 1'b0;
    bank_select_register = 4'h5;
    run(16'h3380, 12'h580, 8'hE6, 8'h73, 3'b000, 1'b1);
    run(16'h3180, 12'h580, 8'h01, 8'h00, 3'b101, 1'b1);
  endtask
  task automatic t_left;
    run(16'h4410, 12'h010, 8'hAB, 8'h57, 3'b100, 1'b1);
    run(16'h47FF, 12'h5FF, 8'h00, 8'h00, 3'b101, 1'b1);
  endtask
  task automatic t_indexed;
    ext_set_en = 1'b1;
    fsr2_base = 12'hFF0;
    run(16'h445F, 12'h04F, 8'h80, 8'h01, 3'b100, 1'b1);
    run(16'h4460, 12'hF60, 8'h40, 8'h80, 3'b110, 1'b1);
    run(16'h4510, 12'h510, 8'h81, 8'h03, 3'b100, 1'b1);
  endtask
  task automatic t_carry_in;
    ext_set_en = 1'b0;
    run(16'h3280, 12'hF80, 8'h00, 8'h80, 3'b010, 1'b1);
    run(16'h4010, 12'h010, 8'h11, 8'h00, 3'b000, 1'b0);
  endtask
  initial begin
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    ext_set_en = 1'b0;
    bank_select_register = 4'h0;
    fsr2_base = 12'h000;
    repeat (20) @(posedge clk_sys);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    t_right();
    t_left();
    t_indexed();
    t_carry_in();
    tally_and_finish();
  end
endmodule
